/* File: dcs_config_status.sv */
// Digitizer timebase, count, range and status register logic
// Function
// - Timebase is internal 10 MHz reference or external input; internal after reset.
// - On source change, sample interval recomputed to nearest achievable period.
// - Source query reports whether internal or external is selected.
// - Negative offset count stored by magnitude as the pretrigger count.
// - One shared sweep count, 1 to 32M or 16M on four channels.
// - Seven ranges 0.0625 to 256; in-between requests round up.
// - Resolution query returns fixed step of the channel's current range.
// - Range query returns addressed channel's range; channel 1 by default.
// - Range change rescales lower and upper limits to same percent.
// - Range change rescales trigger level when that channel is the trigger source; rejected while initiated.
// - Command reset sets every channel to the 256 range.
// - Both status groups have condition, event and enable registers.
// - Ten status registers, four following the 488.2 model.
// - Limit conditions update per sample; event latches once per measurement.
// - Host unmasks standard events and reads status byte summaries.
// - Questionable bits: 0 overload, 8 cal failure, 9-12 limit failures.
// - Operational bits: 0 cal, 5 wait trigger, 8 pretrigger, 9 complete.
`timescale 1ns/1ns
module dcs_config_status
   import dcs_pkg::*;
(
   input logic MCLK_IN,
   input logic SRST_IN,
   input logic CMD_RST_IN,
   input logic MEAS_INIT_IN,
   input logic FOUR_CH_BUILD_IN,
   input logic BACKPLANE_TEN_MHZ_REFERENCE_IN,
   input logic EXT_TIMEBASE_IN,
   input logic TIMEBASE_SOURCE_SELECT_WR_IN,
   input logic TIMEBASE_SOURCE_SELECT_IN,
   input logic EXTERNAL_TIMEBASE_FREQUENCY_WR_IN,
   input logic [24:0] EXTERNAL_TIMEBASE_FREQUENCY_IN,
   input logic SAMP_TICKS_WR_IN,
   input logic [23:0] SAMP_TICKS_IN,
   input logic SWEEP_WR_IN,
   input logic [25:0] SWEEP_PTS_IN,
   input logic PRETRIG_WR_IN,
   input logic PRETRIG_NEG_IN,
   input logic [26:0] PRETRIG_VAL_IN,
   input logic RANGE_WR_IN,
   input logic [2:0] RANGE_CH_IN,
   input logic [12:0] RANGE_REQ_IN,
   input logic [2:0] RANGE_QRY_CH_IN,
   input logic LIMIT_WR_IN,
   input logic LIMIT_UPPER_IN,
   input logic [2:0] LIMIT_CH_IN,
   input logic [31:0] LIMIT_VAL_IN,
   input logic TRIG_LEVEL_WR_IN,
   input logic [31:0] TRIG_LEVEL_IN,
   input logic [2:0] TRIG_SRC_CH_IN,
   input logic CAL_BUSY_IN,
   input logic WAIT_TRIG_IN,
   input logic PRETRIG_MET_IN,
   input logic MEAS_DONE_IN,
   input logic OVERLOAD_IN,
   input logic CAL_FAIL_IN,
   input logic [3:0] LIMIT_FAIL_IN,
   input logic MSG_AVAIL_IN,
   input logic [7:0] STD_EVENT_IN,
   input logic [15:0] ENABLE_DATA_IN,
   input logic OPER_EN_WR_IN,
   input logic QUES_EN_WR_IN,
   input logic STANDARD_EVENT_ENABLE_MASK_WR_IN,
   input logic SERVICE_REQUEST_ENABLE_MASK_WR_IN,
   input logic OPER_EVT_RD_IN,
   input logic QUES_EVT_RD_IN,
   input logic STANDARD_EVENT_STATUS_READ_IN,
   output logic TIMEBASE_SOURCE_SELECT_OUT,
   output logic [24:0] EXTERNAL_TIMEBASE_FREQUENCY_OUT,
   output logic [23:0] SAMP_TICKS_OUT,
   output logic SAMPLE_TICK_OUT,
   output logic [25:0] SWEEP_PTS_OUT,
   output logic [25:0] PRETRIG_CNT_OUT,
   output logic [2:0] RANGE_CODE_OUT,
   output logic [31:0] RESOLUTION_NV_OUT,
   output logic [31:0] LOWER_LIMIT_LEVEL_OUT,
   output logic [31:0] UPPER_LIMIT_OUT,
   output logic [31:0] TRIG_LEVEL_OUT,
   output logic [15:0] OPER_COND_OUT,
   output logic [15:0] OPER_EVT_OUT,
   output logic [15:0] OPER_EN_OUT,
   output logic [15:0] QUES_COND_OUT,
   output logic [15:0] QUES_EVT_OUT,
   output logic [15:0] QUES_EN_OUT,
   output logic [7:0] STANDARD_EVENT_STATUS_READ_OUT,
   output logic [7:0] STANDARD_EVENT_ENABLE_MASK_OUT,
   output logic [7:0] SERVICE_REQUEST_ENABLE_MASK_OUT,
   output logic [7:0] STATUS_BYTE_READ_OUT
);
   // ************************************************************
   // Helpers
   // ************************************************************
   // Channel number 0 stands for channel 1
   function automatic logic [1:0] dcs_ch(input logic [2:0] c);
      return (c == 3'h0) ? 2'h0 : 2'(c - 3'h1);
   endfunction

   function automatic logic dcs_ch_ok(input logic [2:0] c, input logic four);
      return c <= (four ? 3'h4 : 3'h2);
   endfunction

   // Ranges are powers of four, so equal percent of full scale is a shift
   function automatic logic [31:0] dcs_rescale(input logic [31:0] v,
      input logic [2:0] from_i, input logic [2:0] to_i);
      logic signed [31:0] s;
      s = $signed(v);
      if (to_i >= from_i) begin
         s = s <<< {(to_i - from_i), 1'b0};
      end else begin
         s = s >>> {(from_i - to_i), 1'b0};
      end
      return s;
   endfunction

   dcs_state_t r_reg;
   dcs_state_t r_next;
   logic tb_edge;
   logic done_edge;
   logic rng_ok;
   logic [2:0] new_idx;
   logic [1:0] wch;
   logic [25:0] pre_mag;
   logic [49:0] p_ext;
   logic [49:0] p_int;
   logic [49:0] q_sel;
   logic [23:0] recalc;

   // Rounded division; the external frequency is never zero once out of reset
   assign p_ext = 50'(r_reg.samp_ticks) * 50'(r_reg.ext_freq) + 50'(TB_HALF_HZ);
   assign p_int = 50'(r_reg.samp_ticks) * 50'(TB_INT_HZ) + 50'(r_reg.ext_freq[24:1]);
   assign q_sel = (r_reg.src == TB_INT) ? p_ext / 50'(TB_INT_HZ) : p_int / 50'(r_reg.ext_freq);
   assign recalc = (q_sel == 50'h0) ? 24'h000001 :
      (q_sel > 50'(SAMP_TICKS_MAX)) ? SAMP_TICKS_MAX : q_sel[23:0];
   assign wch = dcs_ch(RANGE_CH_IN);
   assign pre_mag = PRETRIG_NEG_IN ? 26'(-PRETRIG_VAL_IN) : PRETRIG_VAL_IN[25:0];

   // ************************************************************
   // Next state
   // ************************************************************
   always_comb begin
      r_next = r_reg;
      tb_edge = (r_reg.src == TB_EXT) ? (EXT_TIMEBASE_IN & ~r_reg.ext_d) :
         (BACKPLANE_TEN_MHZ_REFERENCE_IN & ~r_reg.ref_d);
      done_edge = MEAS_DONE_IN & ~r_reg.meas_d;
      new_idx = RANGE_IDX_MAX;
      for (int i = 6; i >= 0; i--) begin
         if (RANGE_SIXT[i] >= RANGE_REQ_IN) begin
            new_idx = 3'(i);
         end
      end
      rng_ok = dcs_ch_ok(RANGE_CH_IN, FOUR_CH_BUILD_IN) && (RANGE_REQ_IN <= RANGE_SIXT[6]);
      r_next.ref_d = BACKPLANE_TEN_MHZ_REFERENCE_IN;
      r_next.ext_d = EXT_TIMEBASE_IN;
      r_next.meas_d = MEAS_DONE_IN;
      // Sample clock counts edges of the selected timebase
      r_next.samp_tick = 1'b0;
      if (!MEAS_INIT_IN) begin
         r_next.tick_cnt = 24'h000000;
      end else if (tb_edge) begin
         if (r_reg.tick_cnt + 24'h000001 >= r_reg.samp_ticks) begin
            r_next.tick_cnt = 24'h000000;
            r_next.samp_tick = 1'b1;
         end else begin
            r_next.tick_cnt = r_reg.tick_cnt + 24'h000001;
         end
      end
      // Configuration changes are refused while a measurement is initiated
      if (!MEAS_INIT_IN) begin
         if (EXTERNAL_TIMEBASE_FREQUENCY_WR_IN &&
            EXTERNAL_TIMEBASE_FREQUENCY_IN >= EXT_FREQ_MIN &&
            EXTERNAL_TIMEBASE_FREQUENCY_IN <= EXT_FREQ_MAX) begin
            r_next.ext_freq = EXTERNAL_TIMEBASE_FREQUENCY_IN;
         end
         if (SAMP_TICKS_WR_IN && SAMP_TICKS_IN != 24'h000000) begin
            r_next.samp_ticks = SAMP_TICKS_IN;
         end
         if (TIMEBASE_SOURCE_SELECT_WR_IN &&
            dcs_tb_t'(TIMEBASE_SOURCE_SELECT_IN) != r_reg.src) begin
            r_next.src = dcs_tb_t'(TIMEBASE_SOURCE_SELECT_IN);
            r_next.samp_ticks = recalc;
         end
         if (SWEEP_WR_IN && SWEEP_PTS_IN != 26'h0000000 &&
            SWEEP_PTS_IN <= (FOUR_CH_BUILD_IN ? SWEEP_MAX_FOUR : SWEEP_MAX_TWO)) begin
            r_next.sweep = SWEEP_PTS_IN;
         end
         if (PRETRIG_WR_IN && (PRETRIG_VAL_IN[26] == PRETRIG_NEG_IN) &&
            pre_mag <= SWEEP_MAX_TWO) begin
            r_next.pretrig = pre_mag;
         end
         if (LIMIT_WR_IN && dcs_ch_ok(LIMIT_CH_IN, FOUR_CH_BUILD_IN)) begin
            if (LIMIT_UPPER_IN) begin
               r_next.lim_hi[dcs_ch(LIMIT_CH_IN)] = LIMIT_VAL_IN;
            end else begin
               r_next.lim_lo[dcs_ch(LIMIT_CH_IN)] = LIMIT_VAL_IN;
            end
         end
         if (TRIG_LEVEL_WR_IN) begin
            r_next.trig_lvl = TRIG_LEVEL_IN;
         end
         // A range change outranks a same-cycle limit or level write
         if (RANGE_WR_IN && rng_ok) begin
            r_next.rng[wch] = new_idx;
            r_next.lim_lo[wch] = dcs_rescale(r_reg.lim_lo[wch], r_reg.rng[wch], new_idx);
            r_next.lim_hi[wch] = dcs_rescale(r_reg.lim_hi[wch], r_reg.rng[wch], new_idx);
            if (TRIG_SRC_CH_IN != 3'h0 && dcs_ch(TRIG_SRC_CH_IN) == wch) begin
               r_next.trig_lvl = dcs_rescale(r_reg.trig_lvl, r_reg.rng[wch], new_idx);
            end
         end
      end
      if (CMD_RST_IN) begin
         r_next.src = TB_INT;
         r_next.ext_freq = EXT_FREQ_RST;
         r_next.rng = {4{RANGE_IDX_RST}};
      end
      // Query outputs lag the channel select by one cycle
      r_next.rng_q = r_reg.rng[dcs_ch(RANGE_QRY_CH_IN)];
      r_next.res = RES_NV[r_reg.rng[dcs_ch(RANGE_QRY_CH_IN)]];
      r_next.lo_q = r_reg.lim_lo[dcs_ch(RANGE_QRY_CH_IN)];
      r_next.hi_q = r_reg.lim_hi[dcs_ch(RANGE_QRY_CH_IN)];
      // Status groups; in every event register a new set beats a read clear
      r_next.oper_cond = 16'h0000;
      r_next.oper_cond[OPER_CAL_BIT] = CAL_BUSY_IN;
      r_next.oper_cond[OPER_WTRIG_BIT] = WAIT_TRIG_IN;
      r_next.oper_cond[OPER_PRET_BIT] = PRETRIG_MET_IN;
      r_next.oper_cond[OPER_DONE_BIT] = MEAS_DONE_IN;
      r_next.ques_cond[QUES_OVLD_BIT] = OVERLOAD_IN;
      r_next.ques_cond[QUES_CALF_BIT] = CAL_FAIL_IN;
      if (r_next.samp_tick) begin
         r_next.ques_cond[QUES_LIM_LSB +: 4] = LIMIT_FAIL_IN;
      end
      r_next.oper_evt = (OPER_EVT_RD_IN ? 16'h0000 : r_reg.oper_evt) |
         (r_next.oper_cond & ~r_reg.oper_cond);
      // Conditions gathered over the cycle are latched at measurement end
      r_next.ques_evt = (QUES_EVT_RD_IN ? 16'h0000 : r_reg.ques_evt) |
         (done_edge ? (r_reg.ques_acc | r_next.ques_cond) : 16'h0000);
      r_next.ques_acc = done_edge ? 16'h0000 : (r_reg.ques_acc | r_next.ques_cond);
      r_next.esr = (STANDARD_EVENT_STATUS_READ_IN ? 8'h00 : r_reg.esr) | STD_EVENT_IN;
      if (OPER_EN_WR_IN) begin
         r_next.oper_en = ENABLE_DATA_IN;
      end
      if (QUES_EN_WR_IN) begin
         r_next.ques_en = ENABLE_DATA_IN;
      end
      if (STANDARD_EVENT_ENABLE_MASK_WR_IN) begin
         r_next.ese = ENABLE_DATA_IN[7:0];
      end
      if (SERVICE_REQUEST_ENABLE_MASK_WR_IN) begin
         r_next.sre = ENABLE_DATA_IN[7:0];
      end
      r_next.stb = 8'h00;
      r_next.stb[STB_QUES_BIT] = |(r_next.ques_evt & r_next.ques_en);
      r_next.stb[STB_MAV_BIT] = MSG_AVAIL_IN;
      r_next.stb[STB_ESB_BIT] = |(r_next.esr & r_next.ese);
      r_next.stb[STB_OPER_BIT] = |(r_next.oper_evt & r_next.oper_en);
      r_next.stb[STB_MSS_BIT] = |(r_next.stb & r_next.sre & STB_NO_MSS);
      if (SRST_IN) begin
         r_next = '0;
         r_next.src = TB_INT;
         r_next.ext_freq = EXT_FREQ_RST;
         r_next.samp_ticks = SAMP_TICKS_RST;
         r_next.sweep = SWEEP_RST;
         r_next.pretrig = PRETRIG_RST;
         r_next.rng = {4{RANGE_IDX_RST}};
         r_next.res = RES_NV[RANGE_IDX_RST];
         r_next.rng_q = RANGE_IDX_RST;
      end
   end

   always_ff @(posedge MCLK_IN) begin
      r_reg <= r_next;
   end

   assign TIMEBASE_SOURCE_SELECT_OUT = r_reg.src;
   assign EXTERNAL_TIMEBASE_FREQUENCY_OUT = r_reg.ext_freq;
   assign SAMP_TICKS_OUT = r_reg.samp_ticks;
   assign SAMPLE_TICK_OUT = r_reg.samp_tick;
   assign SWEEP_PTS_OUT = r_reg.sweep;
   assign PRETRIG_CNT_OUT = r_reg.pretrig;
   assign RANGE_CODE_OUT = r_reg.rng_q;
   assign RESOLUTION_NV_OUT = r_reg.res;
   assign LOWER_LIMIT_LEVEL_OUT = r_reg.lo_q;
   assign UPPER_LIMIT_OUT = r_reg.hi_q;
   assign TRIG_LEVEL_OUT = r_reg.trig_lvl;
   assign OPER_COND_OUT = r_reg.oper_cond;
   assign OPER_EVT_OUT = r_reg.oper_evt;
   assign OPER_EN_OUT = r_reg.oper_en;
   assign QUES_COND_OUT = r_reg.ques_cond;
   assign QUES_EVT_OUT = r_reg.ques_evt;
   assign QUES_EN_OUT = r_reg.ques_en;
   assign STANDARD_EVENT_STATUS_READ_OUT = r_reg.esr;
   assign STANDARD_EVENT_ENABLE_MASK_OUT = r_reg.ese;
   assign SERVICE_REQUEST_ENABLE_MASK_OUT = r_reg.sre;
   assign STATUS_BYTE_READ_OUT = r_reg.stb;

   // ************************************************************
   // Assertions
   // ************************************************************
   default clocking dcs_cb @(posedge MCLK_IN);
   endclocking
   default disable iff (SRST_IN);

   cmd_rst_src_a: assert property (CMD_RST_IN |=> !TIMEBASE_SOURCE_SELECT_OUT)
      else $error("source not internal after command reset");
   src_keep_a: assert property (TIMEBASE_SOURCE_SELECT_WR_IN && TIMEBASE_SOURCE_SELECT_IN &&
      !TIMEBASE_SOURCE_SELECT_OUT && !MEAS_INIT_IN && !CMD_RST_IN && !SAMP_TICKS_WR_IN &&
      r_reg.ext_freq == TB_INT_HZ |=> $stable(SAMP_TICKS_OUT))
      else $error("interval changed across equal timebases");
   sweep_bound_a: assert property (SWEEP_PTS_OUT != 26'h0 && SWEEP_PTS_OUT <= SWEEP_MAX_TWO)
      else $error("sweep count out of range");
   pre_neg_a: assert property (PRETRIG_WR_IN && PRETRIG_NEG_IN && !MEAS_INIT_IN &&
      PRETRIG_VAL_IN == 27'h7fffffb |=> PRETRIG_CNT_OUT == 26'h0000005)
      else $error("offset magnitude not stored");
   range_up_a: assert property (RANGE_WR_IN && rng_ok && !MEAS_INIT_IN && !CMD_RST_IN |=>
      RANGE_SIXT[r_reg.rng[$past(wch)]] >= $past(RANGE_REQ_IN) &&
      (r_reg.rng[$past(wch)] == 3'h0 ||
      RANGE_SIXT[r_reg.rng[$past(wch)] - 3'h1] < $past(RANGE_REQ_IN)))
      else $error("range not rounded up");
   range_busy_a: assert property (MEAS_INIT_IN && !CMD_RST_IN |=> $stable(r_reg.rng))
      else $error("range changed while initiated");
   range_rst_a: assert property (CMD_RST_IN |=> r_reg.rng == {4{RANGE_IDX_RST}})
      else $error("ranges not restored");
   res_table_a: assert property (RESOLUTION_NV_OUT == RES_NV[RANGE_CODE_OUT])
      else $error("resolution mismatch");
   qry_default_a: assert property (RANGE_QRY_CH_IN == 3'h0 |=>
      RANGE_CODE_OUT == $past(r_reg.rng[0]))
      else $error("default channel not one");
   limit_scale_a: assert property (RANGE_WR_IN && rng_ok && !MEAS_INIT_IN && !CMD_RST_IN &&
      new_idx == r_reg.rng[wch] + 3'h1 |=>
      r_reg.lim_lo[$past(wch)] == 32'($past(r_reg.lim_lo[wch]) << 2))
      else $error("limit not rescaled");
   evt_sticky_a: assert property (!OPER_EVT_RD_IN |=>
      ($past(OPER_EVT_OUT) & ~OPER_EVT_OUT) == 16'h0000)
      else $error("event bit lost without read");
   ques_once_a: assert property (!done_edge && !QUES_EVT_RD_IN |=> $stable(QUES_EVT_OUT))
      else $error("questionable event moved mid cycle");
   esb_sum_a: assert property (STATUS_BYTE_READ_OUT[STB_ESB_BIT] ==
      |(STANDARD_EVENT_STATUS_READ_OUT & STANDARD_EVENT_ENABLE_MASK_OUT))
      else $error("summary bit wrong");

   src_swap_c: cover property (TIMEBASE_SOURCE_SELECT_WR_IN && !MEAS_INIT_IN ##1
      $changed(TIMEBASE_SOURCE_SELECT_OUT));
   range_chg_c: cover property (RANGE_WR_IN && rng_ok && !MEAS_INIT_IN &&
      new_idx != r_reg.rng[wch]);
   lim_fail_c: cover property (done_edge && |r_reg.ques_acc[QUES_LIM_LSB +: 4]);
   srq_c: cover property (STATUS_BYTE_READ_OUT[STB_MSS_BIT]);
endmodule

/* File: dcs_pkg.sv */
// Shared constants and types of the digitizer configuration and status block
package dcs_pkg;
   // ************************************************************
   // Timebase
   // ************************************************************
   localparam logic [24:0] TB_INT_HZ = 25'h0989680;
   localparam logic [24:0] TB_HALF_HZ = 25'h04c4b40;
   localparam logic [24:0] EXT_FREQ_MIN = 25'h00026ac;
   localparam logic [24:0] EXT_FREQ_MAX = 25'h1c9c380;
   localparam logic [24:0] EXT_FREQ_RST = 25'h0989680;
   localparam logic [23:0] SAMP_TICKS_RST = 24'h00000d;
   localparam logic [23:0] SAMP_TICKS_MAX = 24'hffffff;
   typedef enum logic {TB_INT = 1'b0, TB_EXT = 1'b1} dcs_tb_t;
   // ************************************************************
   // Sweep and pretrigger counts
   // ************************************************************
   localparam logic [25:0] SWEEP_MAX_TWO = 26'h2000000;
   localparam logic [25:0] SWEEP_MAX_FOUR = 26'h1000000;
   localparam logic [25:0] SWEEP_RST = 26'h0000001;
   localparam logic [25:0] PRETRIG_RST = 26'h0000000;
   // ************************************************************
   // Channel ranges, in sixteenths of a volt, and resolution in nV
   // ************************************************************
   localparam logic [2:0] RANGE_IDX_RST = 3'h6;
   localparam logic [2:0] RANGE_IDX_MAX = 3'h6;
   localparam logic [6:0][12:0] RANGE_SIXT = {13'h1000, 13'h0400, 13'h0100,
      13'h0040, 13'h0010, 13'h0004, 13'h0001};
   localparam logic [6:0][31:0] RES_NV = {32'h01dcd650, 32'h00773594,
      32'h00773594, 32'h00077359, 32'h0001dcd6, 32'h00007736, 32'h00001dcd};
   // ************************************************************
   // Status bit positions
   // ************************************************************
   localparam int QUES_OVLD_BIT = 0;
   localparam int QUES_CALF_BIT = 8;
   localparam int QUES_LIM_LSB = 9;
   localparam int OPER_CAL_BIT = 0;
   localparam int OPER_WTRIG_BIT = 5;
   localparam int OPER_PRET_BIT = 8;
   localparam int OPER_DONE_BIT = 9;
   localparam int STB_QUES_BIT = 3;
   localparam int STB_MAV_BIT = 4;
   localparam int STB_ESB_BIT = 5;
   localparam int STB_MSS_BIT = 6;
   localparam int STB_OPER_BIT = 7;
   localparam logic [7:0] STB_NO_MSS = 8'hbf;
   typedef struct packed {
      dcs_tb_t src;
      logic [24:0] ext_freq;
      logic [23:0] samp_ticks;
      logic [23:0] tick_cnt;
      logic samp_tick;
      logic ref_d;
      logic ext_d;
      logic meas_d;
      logic [25:0] sweep;
      logic [25:0] pretrig;
      logic [3:0][2:0] rng;
      logic [3:0][31:0] lim_lo;
      logic [3:0][31:0] lim_hi;
      logic [31:0] trig_lvl;
      logic [15:0] oper_cond;
      logic [15:0] oper_evt;
      logic [15:0] oper_en;
      logic [15:0] ques_cond;
      logic [15:0] ques_evt;
      logic [15:0] ques_acc;
      logic [15:0] ques_en;
      logic [7:0] esr;
      logic [7:0] ese;
      logic [7:0] sre;
      logic [7:0] stb;
      logic [2:0] rng_q;
      logic [31:0] res;
      logic [31:0] lo_q;
      logic [31:0] hi_q;
   } dcs_state_t;
endpackage

/* File: dcs_timebase_model.sv */
// Free-running timebase sources seen by the digitizer block
`timescale 1ns/1ns
module dcs_timebase_model (
   output logic REF_OUT,
   output logic EXT_OUT
);
   // Backplane reference at 10 MHz, edges land on falling system clock edges, between rising edges
   initial begin
      REF_OUT = 1'b0;
      forever #50 REF_OUT = ~REF_OUT;
   end
   // External source at 5 MHz; the odd offset keeps its phase unrelated to the clock
   initial begin
      EXT_OUT = 1'b0;
      #7;
      forever #100 EXT_OUT = ~EXT_OUT;
   end
endmodule

/* File: dcs_config_status_tb.sv */
// Self-checking bench for the digitizer configuration and status block
`timescale 1ns/1ns
module dcs_config_status_tb;
   logic clk, rst, init, flag;
   logic [15:0] stb;
   logic [31:0] dat, seed, res_o, lo_o, hi_o, trig_o;
   logic [2:0] ch, rng_o;
   logic [3:0] op, lim;
   logic [1:0] qs;
   logic [7:0] sev, m, v, esr_o, ese_o, stb_o, sre_o;
   logic src_o, tick_p;
   logic [24:0] freq_o;
   logic [23:0] tick_o;
   logic [25:0] swp_o, pre_o;
   logic [15:0] oev_o, qev_o, qc_o, oc_o, oen_o, qen_o;
   wire ref_w, ext_w;
   int error_cnt, num_checks, cyc;
   int sixt[7] = '{1, 4, 16, 64, 256, 1024, 4096};
   int resv[7] = '{7629, 30518, 122070, 488281, 7812500, 7812500, 31250000};
   int sv[5] = '{33554432, 33554433, 0, 16777217, 16777216};
   int se[5] = '{33554432, 33554432, 33554432, 33554432, 16777216};
   logic [31:0] pv[3] = '{32'hfffffffb, 32'h32, 32'h32};
   int pe[3] = '{5, 50, 50};
   dcs_timebase_model TBM (.REF_OUT(ref_w), .EXT_OUT(ext_w));
   dcs_config_status DUT (
      .MCLK_IN(clk), .SRST_IN(rst), .CMD_RST_IN(stb[7]), .MEAS_INIT_IN(init),
      .FOUR_CH_BUILD_IN(flag), .BACKPLANE_TEN_MHZ_REFERENCE_IN(ref_w), .EXT_TIMEBASE_IN(ext_w),
      .TIMEBASE_SOURCE_SELECT_WR_IN(stb[0]), .TIMEBASE_SOURCE_SELECT_IN(dat[0]),
      .EXTERNAL_TIMEBASE_FREQUENCY_WR_IN(stb[1]), .EXTERNAL_TIMEBASE_FREQUENCY_IN(dat[24:0]),
      .SAMP_TICKS_WR_IN(stb[2]), .SAMP_TICKS_IN(dat[23:0]), .SWEEP_WR_IN(stb[3]),
      .SWEEP_PTS_IN(dat[25:0]), .PRETRIG_WR_IN(stb[4]), .PRETRIG_NEG_IN(flag),
      .PRETRIG_VAL_IN(dat[26:0]), .RANGE_WR_IN(stb[5]), .RANGE_CH_IN(ch),
      .RANGE_REQ_IN(dat[12:0]), .RANGE_QRY_CH_IN(ch), .LIMIT_WR_IN(stb[6]),
      .LIMIT_UPPER_IN(flag), .LIMIT_CH_IN(ch), .LIMIT_VAL_IN(dat), .TRIG_LEVEL_WR_IN(stb[14]),
      .TRIG_LEVEL_IN(dat), .TRIG_SRC_CH_IN(ch), .CAL_BUSY_IN(op[0]), .WAIT_TRIG_IN(op[1]),
      .PRETRIG_MET_IN(op[2]), .MEAS_DONE_IN(op[3]), .OVERLOAD_IN(qs[0]), .CAL_FAIL_IN(qs[1]),
      .LIMIT_FAIL_IN(lim), .MSG_AVAIL_IN(1'b0), .STD_EVENT_IN(sev), .ENABLE_DATA_IN(dat[15:0]),
      .OPER_EN_WR_IN(stb[12]), .QUES_EN_WR_IN(stb[13]),
      .STANDARD_EVENT_ENABLE_MASK_WR_IN(stb[11]), .SERVICE_REQUEST_ENABLE_MASK_WR_IN(stb[15]),
      .OPER_EVT_RD_IN(stb[9]), .QUES_EVT_RD_IN(stb[8]), .STANDARD_EVENT_STATUS_READ_IN(stb[10]),
      .TIMEBASE_SOURCE_SELECT_OUT(src_o), .EXTERNAL_TIMEBASE_FREQUENCY_OUT(freq_o),
      .SAMP_TICKS_OUT(tick_o), .SAMPLE_TICK_OUT(tick_p), .SWEEP_PTS_OUT(swp_o),
      .PRETRIG_CNT_OUT(pre_o), .RANGE_CODE_OUT(rng_o), .RESOLUTION_NV_OUT(res_o),
      .LOWER_LIMIT_LEVEL_OUT(lo_o), .UPPER_LIMIT_OUT(hi_o), .TRIG_LEVEL_OUT(trig_o),
      .OPER_COND_OUT(oc_o), .OPER_EVT_OUT(oev_o), .OPER_EN_OUT(oen_o), .QUES_COND_OUT(qc_o),
      .QUES_EVT_OUT(qev_o), .QUES_EN_OUT(qen_o), .STANDARD_EVENT_STATUS_READ_OUT(esr_o),
      .STANDARD_EVENT_ENABLE_MASK_OUT(ese_o), .SERVICE_REQUEST_ENABLE_MASK_OUT(sre_o),
      .STATUS_BYTE_READ_OUT(stb_o)
   );
   // ************************************************************
   // Tasks
   // ************************************************************
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: %s got %0h exp %0h", $time, msg, got, exp);
      end
   endtask
   // Strobe k for one edge with shared data; results read once the query regs settle
   task automatic pulse(input int k, input logic [31:0] d, input logic [2:0] c, input logic f);
      @(posedge clk);
      stb[k] <= 1'b1;
      dat <= d;
      ch <= c;
      flag <= f;
      @(posedge clk);
      stb <= '0;
      @(posedge clk);
      @(negedge clk);
   endtask
   task automatic try_range(input int req, input logic [2:0] c);
      int k;
      k = 0;
      while (k < 6 && sixt[k] < req) k++;
      pulse(5, req, c, 1'b0);
      chk(rng_o, k, "range code");
      chk(res_o, resv[k], "resolution");
   endtask
   // Cycles between two sample ticks; the first tick may follow a partial count
   task automatic tick_gap(input int exp);
      int n;
      n = 0;
      while (tick_p !== 1'b1 && n < 300) begin
         @(negedge clk);
         n++;
      end
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (tick_p !== 1'b1 && n < 300);
      chk(n, exp, "sample gap");
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // ************************************************************
   // Sequence
   // ************************************************************
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         error_cnt++;
         summarize();
      end
   end
   initial begin
      {init, flag, stb, dat, ch, op, lim, qs, sev} = '0;
      rst = 1'b1;
      seed = 32'h624ba261;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(negedge clk);
      chk(src_o, 0, "reset source");
      chk(freq_o, 25'h0989680, "reset freq");
      chk(rng_o, 6, "reset range");
      $display("test reset done");
      for (int i = 0; i < 7; i++) begin
         try_range(sixt[i], 3'h1);
         if (i < 6) try_range(sixt[i] + 1, 3'h1);
      end
      for (int i = 0; i < 6; i++) begin
         seed = xs(seed);
         try_range((seed % 4096) + 1, seed[16] ? 3'h2 : 3'h0);
      end
      try_range(4096, 3'h1);
      pulse(6, 32'd256000, 3'h1, 1'b0);
      pulse(6, 32'd512000, 3'h1, 1'b1);
      pulse(14, 32'd256000, 3'h1, 1'b0);
      try_range(16, 3'h1);
      chk(lo_o, 32'd1000, "limit rescale");
      chk(hi_o, 32'd2000, "upper rescale");
      chk(trig_o, 32'd1000, "trigger rescale");
      $display("test range done");
      for (int i = 0; i < 5; i++) begin
         pulse(3, sv[i], 3'h0, i > 2);
         chk(swp_o, se[i], "sweep");
      end
      for (int i = 0; i < 3; i++) begin
         pulse(4, pv[i], 3'h0, i != 1);
         chk(pre_o, pe[i], "pretrigger");
      end
      $display("test counts done");
      pulse(2, 32'd20, 3'h1, 1'b0);
      pulse(1, 32'h004c4b40, 3'h1, 1'b0);
      pulse(0, 32'h1, 3'h1, 1'b0);
      chk(src_o, 1, "source ext");
      chk(tick_o, 10, "ticks to ext");
      @(posedge clk);
      init <= 1'b1;
      tick_gap(40);
      @(posedge clk);
      init <= 1'b0;
      pulse(0, 32'h0, 3'h1, 1'b0);
      chk(src_o, 0, "source int");
      chk(tick_o, 20, "ticks to int");
      $display("test timebase done");
      pulse(13, 32'h0200, 3'h1, 1'b0);
      pulse(12, 32'h0200, 3'h1, 1'b0);
      chk({oen_o, qen_o}, 32'h02000200, "enables");
      @(posedge clk);
      init <= 1'b1;
      lim <= 4'h1;
      qs <= 2'b11;
      pulse(5, 32'h1, 3'h1, 1'b0);
      chk(rng_o, 2, "range while busy");
      tick_gap(40);
      @(negedge clk);
      chk(qc_o, 16'h0301, "ques cond");
      @(posedge clk);
      op[3] <= 1'b1;
      qs <= 2'b00;
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk(qev_o, 16'h0301, "ques latch");
      chk(oev_o[9], 1, "oper done");
      chk(stb_o[3], 1, "ques summary");
      chk(stb_o[7], 1, "oper summary");
      chk(oc_o[9], 1, "oper cond");
      pulse(15, 32'h0088, 3'h0, 1'b0);
      chk(sre_o, 8'h88, "service enable");
      chk(stb_o[6], 1, "service request");
      @(posedge clk);
      op[3] <= 1'b0;
      lim <= 4'h0;
      init <= 1'b0;
      repeat (3) @(negedge clk);
      chk(qev_o, 16'h0301, "ques held");
      chk(qev_o[12:9], 4'h1, "limit failure latched");
      pulse(8, 32'h0, 3'h1, 1'b0);
      chk(qev_o, 0, "ques read");
      pulse(9, 32'h0, 3'h1, 1'b0);
      chk(oev_o, 0, "oper read");
      for (int i = 0; i < 4; i++) begin
         seed = xs(seed);
         m = seed[7:0];
         v = seed[15:8];
         pulse(11, {24'h0, m}, 3'h0, 1'b0);
         @(posedge clk);
         sev <= v;
         @(posedge clk);
         sev <= '0;
         @(posedge clk);
         @(negedge clk);
         chk(ese_o, m, "std enable");
         chk(esr_o, v, "std event");
         chk(stb_o[5], |(v & m), "event summary");
         pulse(10, 32'h0, 3'h0, 1'b0);
         chk(esr_o, 0, "std read");
      end
      $display("test status done");
      pulse(0, 32'h1, 3'h0, 1'b0);
      pulse(7, 32'h0, 3'h0, 1'b0);
      chk(src_o, 0, "cmd reset source");
      chk(rng_o, 6, "cmd reset range");
      pulse(0, 32'h1, 3'h0, 1'b0);
      chk(tick_o, 10, "ticks equal base");
      $display("test command reset done");
      summarize();
   end
endmodule
